// ==== hw/cms_pkg.sv ====
// Constants shared by the configuration scheme select and power-on reset block
package cms_pkg;

  // Clock and serial clock rates
  localparam int CLK_HZ = 100_000_000;
  localparam int SCLK_MAX_HZ = 40_000_000;
  localparam int SCLK_TYP_HZ = 30_000_000;
  // Half period of the serial clock in cycles, rounded up so the rate never exceeds the limit
  localparam int SCLK_HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int DIV_W = 4;

  // Power-on reset windows in milliseconds and the chosen targets inside them
  localparam int POR_FAST_MIN_MS = 3;
  localparam int POR_FAST_MAX_MS = 9;
  localparam int POR_FAST_MS = 6;
  localparam int POR_STD_MIN_MS = 50;
  localparam int POR_STD_MAX_MS = 200;
  localparam int POR_STD_MS = 100;
  localparam int POR_FAST_CYCLES = POR_FAST_MS * (CLK_HZ / 1000);
  localparam int POR_STD_CYCLES = POR_STD_MS * (CLK_HZ / 1000);
  localparam int POR_CNT_W = 24;

  // Scheme-select codes for active serial mode, most significant bit first
  localparam logic [3:0] SEL_AS_STD_33 = 4'h2;
  localparam logic [3:0] SEL_AS_STD_25 = 4'h3;
  localparam logic [3:0] SEL_AS_FAST_25 = 4'h4;
  localparam logic [3:0] SEL_AS_FAST_33 = 4'hD;

  // Flash read command and header length
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [5:0] CMD_LAST_BIT = 6'h1F;
  localparam logic [5:0] WORD_LAST_BIT = 6'h1F;

  // Compressed stream: marker in the upper half, zero-run length in the lower half
  localparam logic [15:0] RUN_MARK = 16'hFFFE;

  // APB register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_WORDS = 12'h008;

  // Control register fields and reset value
  localparam int CTRL_DECOMP_BIT = 0;
  localparam int CTRL_REMOTE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register field positions
  localparam int ST_FAST_BIT = 8;
  localparam int ST_AS_BIT = 9;
  localparam int ST_JTAG_BIT = 10;
  localparam int ST_STATLINE_BIT = 11;
  localparam int ST_COMPLETE_BIT = 12;
  localparam int ST_SEL_LSB = 16;

  // Synchroniser bit positions
  localparam int SY_SUP = 0;
  localparam int SY_REQ = 1;
  localparam int SY_STAT = 2;
  localparam int SY_DONE = 3;
  localparam int SY_JTAG = 4;
  localparam int SY_DIN = 5;
  localparam int SY_SEL = 6;
  localparam int SY_W = 10;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_POR = 6'h01,
    ST_RESET = 6'h02,
    ST_CMD = 6'h04,
    ST_READ = 6'h08,
    ST_DONE = 6'h10,
    ST_HOLD = 6'h20
  } cms_state_t;

endpackage

// ==== hw/cms_config_loader.sv ====
// Power-on reset sequencer, scheme decode and active serial bitstream loader
//
// How it works
// - The status line is driven low until all monitored supplies report above the trip point.
// - A fast reset scheme holds power-on reset for 6 ms, inside the 3 ms to 9 ms window.
// - A standard reset scheme holds power-on reset for 100 ms, inside the 50 ms to 200 ms window.
// - While anyone holds the status line low the device stays in reset, whatever window applies.
// - A boundary-scan configuration request overrides the strapped scheme, which then sets only the reset length.
// - The reset length still follows the strap pins when boundary-scan configuration is used.
// - Codes 0010 and 0011 select standard and 0100 and 1101 fast reset in active serial mode.
// - Without the top strap bit, fast active serial at 2.5 or 3.0 V is not offered.
// - Remote update may be enabled by option only in the active schemes.
// - Remote update and decompression may be used together in active serial mode.
// - The serial clock is generated at no more than 40 MHz.
// - The bitstream is read over the serial link, expanded when compressed, and written out.
// - In active serial mode this block is the link master and the flash only answers.
// - The block stays in reset while the configuration request line or status line is low.
// - During power-on reset the status and complete lines are driven low and user pins float.
//
// Our own choices: the register offsets and register access over APB.

// Small FIFO with valid and ready on both sides
module cms_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } cms_fifo_t;

  cms_fifo_t s;
  cms_fifo_t next_s;
  logic push;
  logic pop;

  // Flags and read port
  assign in_ready_out = (s.cnt != FULL_CNT);
  assign out_valid_out = (s.cnt != '0);
  assign out_data_out = s.mem[s.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data_in;
      next_s.wr = (s.wr == LAST_IDX) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == LAST_IDX) ? '0 : s.rd + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= next_s;
    end
  end
endmodule

module cms_config_loader
  import cms_pkg::*;
#(
  parameter bit HAS_TOP_BIT = 1'b1,
  parameter int CFG_WORDS = 16,
  parameter int FIFO_DEPTH = 4,
  parameter int POR_FAST_CNT = POR_FAST_CYCLES,
  parameter int POR_STD_CNT = POR_STD_CYCLES,
  parameter logic [23:0] START_ADDR = 24'h000000
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Power and configuration pins
  input wire logic supplies_ok_in,
  input wire logic config_request_n_in,
  input wire logic jtag_config_in,
  input wire logic [3:0] scheme_select_pins_in,
  input wire logic status_line_in,
  output logic status_line_out,
  output logic status_line_oe_n_out,
  input wire logic config_complete_line_in,
  output logic config_complete_line_out,
  output logic config_complete_line_oe_n_out,
  output logic user_io_release_out,
  output logic remote_update_active_out,
  // Serial flash link
  output logic config_serial_clock_out,
  output logic flash_cs_n_out,
  output logic flash_data_out,
  input wire logic flash_data_in,
  // Configuration memory write port
  output logic [31:0] cfg_word_out,
  output logic cfg_word_valid_out,
  input wire logic cfg_word_ready_in
);
  localparam logic [POR_CNT_W-1:0] FAST_TGT = POR_CNT_W'(POR_FAST_CNT);
  localparam logic [POR_CNT_W-1:0] STD_TGT = POR_CNT_W'(POR_STD_CNT);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF_CYC - 1);
  localparam logic [15:0] WORDS_TGT = 16'(CFG_WORDS);

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    cms_state_t state;
    logic [3:0] sel;
    logic [POR_CNT_W-1:0] por_cnt;
    logic [DIV_W-1:0] div;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [31:0] shreg;
    logic [5:0] bitcnt;
    logic [15:0] wordcnt;
    logic pend_valid;
    logic [31:0] pend_word;
    logic [15:0] run_left;
    logic [1:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] out_word;
    logic out_valid;
    logic stat_oe_n;
    logic done_oe_n;
    logic remote_act;
    logic user_rel;
  } cms_top_t;

  localparam cms_top_t TOP_RST = '{state: ST_POR, cs_n: 1'b1, ctrl: CTRL_RESET, default: '0};

  cms_top_t s;
  cms_top_t next_s;
  logic sup_ok;
  logic req_high;
  logic stat_high;
  logic jtag_req;
  logic din;
  logic [3:0] sel_pins;
  logic fast_por;
  logic as_mode;
  logic [POR_CNT_W-1:0] por_target;
  logic is_run;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [31:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic sclk_run;
  logic sclk_tick;
  logic apb_access;
  logic [31:0] status_word;

  // Synchronised pin levels, read only from the second stage
  assign sup_ok = s.sync2[SY_SUP];
  assign req_high = s.sync2[SY_REQ];
  assign stat_high = s.sync2[SY_STAT];
  assign jtag_req = s.sync2[SY_JTAG];
  assign din = s.sync2[SY_DIN];
  // Missing top strap bit reads as zero
  assign sel_pins = {s.sync2[SY_SEL+3] & HAS_TOP_BIT, s.sync2[SY_SEL+2:SY_SEL]};

  // Scheme decode; the reset length ignores the boundary-scan override
  assign fast_por = (s.sel == SEL_AS_FAST_33) || (HAS_TOP_BIT && s.sel == SEL_AS_FAST_25);
  assign por_target = fast_por ? FAST_TGT : STD_TGT;
  assign as_mode = !jtag_req && (s.sel == SEL_AS_STD_33 || s.sel == SEL_AS_STD_25 || fast_por);

  // Decompression of zero runs and FIFO feed
  assign is_run = s.ctrl[CTRL_DECOMP_BIT] && (s.pend_word[31:16] == RUN_MARK);
  assign fifo_in_valid = s.pend_valid && !(is_run && s.run_left == '0);
  assign fifo_in_data = is_run ? 32'h00000000 : s.pend_word;
  assign fifo_out_ready = !s.out_valid || cfg_word_ready_in;

  // Serial clock divider runs in the command and read states unless a word is waiting or all words are in
  assign sclk_run = (s.state == ST_CMD) || (s.state == ST_READ && !s.pend_valid && s.wordcnt != WORDS_TGT);
  assign sclk_tick = sclk_run && (s.div == DIV_LAST);

  assign apb_access = psel_in && penable_in;
  assign status_word = {12'h000, s.sel, 3'h0, s.sync2[SY_DONE], stat_high, jtag_req, as_mode, fast_por,
                        2'h0, s.state};

  cms_fifo #(
    .W(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(ref_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .in_valid_in(fifo_in_valid),
    .in_data_in(fifo_in_data),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_out_ready)
  );

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    next_s.sync1 = {scheme_select_pins_in, flash_data_in, jtag_config_in, config_complete_line_in,
                    status_line_in, config_request_n_in, supplies_ok_in};
    next_s.sync2 = s.sync1;

    // Pending word drains into the FIFO, runs expand to zero words
    if (s.pend_valid) begin
      if (is_run) begin
        if (s.run_left == '0) begin
          next_s.pend_valid = 1'b0;
        end else if (fifo_in_ready) begin
          next_s.run_left = s.run_left - 1'b1;
          next_s.pend_valid = (s.run_left != 16'h0001);
        end
      end else if (fifo_in_ready) begin
        next_s.pend_valid = 1'b0;
      end
    end

    // Output stage toward configuration memory
    if (fifo_out_valid && fifo_out_ready) begin
      next_s.out_word = fifo_out_data;
      next_s.out_valid = 1'b1;
    end else if (cfg_word_ready_in) begin
      next_s.out_valid = 1'b0;
    end

    // Divider and serial clock
    if (sclk_run) begin
      next_s.div = sclk_tick ? '0 : s.div + 1'b1;
      if (sclk_tick) begin
        next_s.sclk = !s.sclk;
      end
    end

    case (s.state)
      ST_POR: begin
        // Hold lines low and time the reset window
        next_s.stat_oe_n = 1'b0;
        next_s.done_oe_n = 1'b0;
        next_s.user_rel = 1'b0;
        next_s.sel = sel_pins;
        if (s.por_cnt == por_target) begin
          next_s.state = ST_RESET;
          next_s.stat_oe_n = 1'b1;
        end else begin
          next_s.por_cnt = s.por_cnt + 1'b1;
        end
      end
      ST_RESET: begin
        // Wait for request and status lines both high
        if (req_high && stat_high) begin
          if (as_mode) begin
            next_s.state = ST_CMD;
            next_s.cs_n = 1'b0;
            next_s.shreg = {FLASH_READ_CMD, START_ADDR};
            next_s.mosi = FLASH_READ_CMD[7];
            next_s.bitcnt = '0;
            next_s.wordcnt = '0;
            next_s.div = '0;
            next_s.sclk = 1'b0;
          end else begin
            next_s.state = ST_HOLD;
          end
        end
      end
      ST_CMD: begin
        // Command bits change on the falling edge
        if (sclk_tick && s.sclk) begin
          if (s.bitcnt == CMD_LAST_BIT) begin
            next_s.state = ST_READ;
            next_s.bitcnt = '0;
          end else begin
            next_s.shreg = {s.shreg[30:0], 1'b0};
            next_s.mosi = s.shreg[30];
            next_s.bitcnt = s.bitcnt + 1'b1;
          end
        end
      end
      ST_READ: begin
        // Data bits are taken on the falling edge
        if (sclk_tick && s.sclk) begin
          next_s.shreg = {s.shreg[30:0], din};
          next_s.bitcnt = s.bitcnt + 1'b1;
          if (s.bitcnt == WORD_LAST_BIT) begin
            next_s.bitcnt = '0;
            next_s.pend_valid = 1'b1;
            next_s.pend_word = {s.shreg[30:0], din};
            next_s.run_left = {s.shreg[14:0], din};
            next_s.wordcnt = s.wordcnt + 1'b1;
          end
        end
        if (s.wordcnt == WORDS_TGT && !s.pend_valid && !fifo_out_valid && !s.out_valid) begin
          next_s.state = ST_DONE;
          next_s.cs_n = 1'b1;
          next_s.sclk = 1'b0;
          next_s.done_oe_n = 1'b1;
          next_s.user_rel = 1'b1;
        end
      end
      ST_DONE, ST_HOLD: begin
      end
      default: begin
        next_s.state = ST_POR;
      end
    endcase

    // Leaving reset is undone when either line drops
    if (s.state != ST_POR && s.state != ST_RESET && (!req_high || !stat_high)) begin
      next_s.state = ST_RESET;
      next_s.cs_n = 1'b1;
      next_s.sclk = 1'b0;
      next_s.div = '0;
      next_s.pend_valid = 1'b0;
      next_s.done_oe_n = 1'b0;
      next_s.user_rel = 1'b0;
    end

    // Supply drop restarts power-on reset
    if (!sup_ok) begin
      next_s.state = ST_POR;
      next_s.por_cnt = '0;
      next_s.stat_oe_n = 1'b0;
      next_s.done_oe_n = 1'b0;
      next_s.user_rel = 1'b0;
      next_s.cs_n = 1'b1;
      next_s.sclk = 1'b0;
      next_s.pend_valid = 1'b0;
    end

    // Remote update only in active serial mode, alongside decompression
    next_s.remote_act = s.ctrl[CTRL_REMOTE_BIT] && as_mode && s.state != ST_POR;

    // APB slave: one wait state, then the answer
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (apb_access && !s.pready) begin
      next_s.pready = 1'b1;
      case (paddr_in)
        ADDR_CTRL: next_s.prdata = {30'h00000000, s.ctrl};
        ADDR_STATUS: next_s.prdata = status_word;
        ADDR_WORDS: next_s.prdata = {16'h0000, s.wordcnt};
        default: begin
          next_s.prdata = 32'h00000000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_access && s.pready && pwrite_in && paddr_in == ADDR_CTRL) begin
      next_s.ctrl = pwdata_in[1:0];
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s <= TOP_RST;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  // Outputs
  assign prdata_out = s.prdata;
  assign pready_out = s.pready;
  assign pslverr_out = s.pslverr;
  assign status_line_out = 1'b0;
  assign status_line_oe_n_out = s.stat_oe_n;
  assign config_complete_line_out = 1'b0;
  assign config_complete_line_oe_n_out = s.done_oe_n;
  assign user_io_release_out = s.user_rel;
  assign remote_update_active_out = s.remote_act;
  assign config_serial_clock_out = s.sclk;
  assign flash_cs_n_out = s.cs_n;
  assign flash_data_out = s.mosi;
  assign cfg_word_out = s.out_word;
  assign cfg_word_valid_out = s.out_valid;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_fetch_begin;
    $fell(flash_cs_n_out);
  endsequence

  sequence s_first_cmd_bit;
    flash_data_out == FLASH_READ_CMD[7] && !config_serial_clock_out;
  endsequence

  a_por_holds_lines: assert property (
    s.state == ST_POR |-> !status_line_oe_n_out && !config_complete_line_oe_n_out && !user_io_release_out)
    else $error("lines not held low in power-on reset");
  a_supply_low_por: assert property (
    ce_in && !sup_ok |=> s.state == ST_POR && !status_line_oe_n_out)
    else $error("supply drop did not restart power-on reset");
  a_por_exit_count: assert property (
    $past(s.state) == ST_POR && s.state == ST_RESET |-> $past(s.por_cnt) == $past(por_target))
    else $error("power-on reset left at wrong count");
  a_fast_target: assert property (fast_por |-> por_target == FAST_TGT && as_mode == !jtag_req)
    else $error("fast strap gives wrong window");
  a_std_target: assert property (
    (s.sel == SEL_AS_STD_33 || s.sel == SEL_AS_STD_25) |-> por_target == STD_TGT)
    else $error("standard strap gives wrong window");
  a_reset_hold: assert property (
    ce_in && s.state != ST_POR && (!req_high || !stat_high) |=>
    (s.state == ST_RESET || s.state == ST_POR) && flash_cs_n_out) else $error("left reset while line low");
  a_jtag_no_fetch: assert property (jtag_req && s.state == ST_RESET |=> flash_cs_n_out)
    else $error("strapped fetch began under boundary-scan");
  a_no_top_bit: assert property (!HAS_TOP_BIT |-> !(s.sel == SEL_AS_FAST_25 && fast_por))
    else $error("fast low-voltage scheme on variant without top bit");
  a_remote_as_only: assert property (remote_update_active_out |-> $past(as_mode))
    else $error("remote update outside active serial");
  a_sclk_rate: assert property ($changed(config_serial_clock_out) |=> !$changed(config_serial_clock_out))
    else $error("serial clock faster than allowed");
  a_cmd_first_bit: assert property (s_fetch_begin |-> s_first_cmd_bit)
    else $error("fetch did not open with the read command");
endmodule

// ==== verification/cms_flash_model.sv ====
// Behavioural serial configuration flash that answers one read command per frame
module cms_flash_model (
  // Link from the loader
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  // Answer and observations
  output logic miso_out,
  output logic [31:0] cmd_out,
  output int fast_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int rcnt = 0;
  int fcnt = 0;
  realtime last = 0;
  logic [31:0] cur;

  // Idle values
  initial begin
    miso_out = 1'h0;
    cmd_out = 32'h0;
    fast_out = 0;
  end

  // Frame start clears the bit counters
  always @(negedge cs_n_in) begin
    rcnt = 0;
    fcnt = 0;
    last = 0;
  end

  // Command latched on rising edges; clock periods under 25 ns are flagged
  always @(posedge sclk_in) begin
    if (!cs_n_in) begin
      if (rcnt < 32) cmd_out = {cmd_out[30:0], mosi_in};
      if ($realtime - last < 25.0) fast_out++;
      last = $realtime;
      rcnt++;
    end
  end

  // Data driven on falling edges once the command is in; word 2 is a zero-run marker
  always @(negedge sclk_in) begin
    if (!cs_n_in && rcnt >= 32) begin
      cur = (fcnt / 32 == 2) ? 32'hFFFE_0002 : 32'hC0DE_0000 + 32'(fcnt / 32);
      miso_out = cur[31 - fcnt % 32];
      fcnt++;
    end
  end

  // A released line never keeps showing its old level
  always @(posedge cs_n_in) miso_out = ~miso_out;
endmodule

// ==== verification/test_config_mode_select_por.sv ====
// Testbench for the scheme select, power-on reset and serial loader block
module test_config_mode_select_por
  import cms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int FC = 20;
  localparam int SC = 50;

  logic ref_clk_in = 1'h0;
  logic reset_in = 1'h1;
  logic ce_in = 1'h1;
  logic psel_in = 1'h0;
  logic penable_in = 1'h0;
  logic pwrite_in = 1'h0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic supplies_ok_in = 1'h1;
  logic config_request_n_in = 1'h1;
  logic jtag_config_in = 1'h0;
  logic [3:0] scheme_select_pins_in = 4'hD;
  logic stat_hold = 1'h0;
  logic cfg_word_ready_in = 1'h1;
  logic [31:0] prdata_out, cfg_word_out, fl_cmd;
  logic pready_out, pslverr_out, status_line_out, status_line_oe_n_out, config_complete_line_out;
  logic config_complete_line_oe_n_out, user_io_release_out, remote_update_active_out;
  logic config_serial_clock_out, flash_cs_n_out, flash_data_out, flash_data_in, cfg_word_valid_out;
  int fl_fast;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] got[$];

  // Open-drain wires with pull-ups; stat_hold is an outside party pulling low
  wire status_line_in = (status_line_oe_n_out ? 1'h1 : status_line_out) & ~stat_hold;
  wire config_complete_line_in = config_complete_line_oe_n_out ? 1'h1 : config_complete_line_out;

  cms_config_loader #(.POR_FAST_CNT(FC), .POR_STD_CNT(SC)) dut (
    .ref_clk_in, .reset_in, .ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .supplies_ok_in, .config_request_n_in, .jtag_config_in,
    .scheme_select_pins_in, .status_line_in, .status_line_out, .status_line_oe_n_out,
    .config_complete_line_in, .config_complete_line_out, .config_complete_line_oe_n_out,
    .user_io_release_out, .remote_update_active_out, .config_serial_clock_out, .flash_cs_n_out,
    .flash_data_out, .flash_data_in, .cfg_word_out, .cfg_word_valid_out, .cfg_word_ready_in
  );

  cms_flash_model fl (.sclk_in(config_serial_clock_out), .cs_n_in(flash_cs_n_out),
    .mosi_in(flash_data_out), .miso_out(flash_data_in), .cmd_out(fl_cmd), .fast_out(fl_fast));

  // Clock
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Collect accepted memory words; cut a hang short
  always @(posedge ref_clk_in) begin
    if (cfg_word_valid_out === 1'h1 && cfg_word_ready_in) got.push_back(cfg_word_out);
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      $display("[FAIL] %0t run timed out", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask

  task wrap_up();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wf(ref logic s, input logic v, input int mx, input string m);
    int n = 0;
    while (s !== v && n < mx) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(32'(s), 32'(v), m);
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge ref_clk_in);
    psel_in <= 1'h1;
    penable_in <= 1'h0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'h1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready_out !== 1'h1 && n < 20);
    if (n == 20) err_total++;
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask

  task automatic rst(input logic [3:0] c, input logic j);
    @(posedge ref_clk_in);
    reset_in <= 1'h1;
    scheme_select_pins_in <= c;
    jtag_config_in <= j;
    got.delete();
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'h0;
  endtask

  // Cycles from reset release until the status line is let go
  task automatic por(output int n);
    n = 0;
    while (status_line_oe_n_out !== 1'h1 && n < 400) begin
      @(posedge ref_clk_in);
      n++;
      if (n == 5) begin
        chk(32'({status_line_oe_n_out, config_complete_line_oe_n_out, user_io_release_out}), 32'h0, "pins");
      end
    end
  endtask

  function automatic logic [31:0] fw(int i);
    return (i == 2) ? 32'hFFFE_0002 : 32'hC0DE_0000 + 32'(i);
  endfunction

  // Full fetch for one strap code, optional decompression and memory stall
  task automatic as_run(input logic [3:0] c, input logic dc, input logic st);
    int n, cnt;
    logic [31:0] r, q[$];
    logic e, fast;
    fast = (c == SEL_AS_FAST_25) || (c == SEL_AS_FAST_33);
    cnt = fast ? FC : SC;
    rst(c, 1'h0);
    cfg_word_ready_in <= ~st;
    fork
      por(n);
      apb(1'h1, ADDR_CTRL, {30'h0, 1'h1, dc}, r, e);
    join
    chk(32'(n > cnt && n <= cnt + 8), 32'h1, "por length");
    apb(1'h0, ADDR_STATUS, 32'h0, r, e);
    chk(32'({r[ST_AS_BIT], r[ST_FAST_BIT]}), 32'({1'h1, fast}), "decode");
    if (st) begin
      repeat (1500) @(posedge ref_clk_in);
      chk(32'(got.size()), 32'h0, "stall");
      cfg_word_ready_in <= 1'h1;
    end
    wf(user_io_release_out, 1'h1, 4000, "done");
    chk(32'({config_complete_line_oe_n_out, flash_cs_n_out, remote_update_active_out}), 32'h7,
        "end");
    for (int i = 0; i < 16; i++) begin
      if (i == 2 && dc) begin
        q.push_back(32'h0);
        q.push_back(32'h0);
      end else begin
        q.push_back(fw(i));
      end
    end
    chk(32'(got.size()), 32'(q.size()), "count");
    foreach (q[i]) chk(got[i], q[i], "word");
    chk(fl_cmd, {FLASH_READ_CMD, 24'h0}, "command");
    chk(32'(fl_fast), 32'h0, "clock rate");
    apb(1'h0, ADDR_WORDS, 32'h0, r, e);
    chk(r, 32'h10, "words");
  endtask

  // Supplies, request line and outside hold of the status line
  task automatic ctl_run();
    int n;
    supplies_ok_in <= 1'h0;
    config_request_n_in <= 1'h0;
    rst(SEL_AS_FAST_33, 1'h0);
    repeat (100) @(posedge ref_clk_in);
    chk(32'(status_line_oe_n_out), 32'h0, "supply low");
    supplies_ok_in <= 1'h1;
    por(n);
    repeat (200) @(posedge ref_clk_in);
    chk(32'(flash_cs_n_out), 32'h1, "request low");
    stat_hold <= 1'h1;
    config_request_n_in <= 1'h1;
    repeat (200) @(posedge ref_clk_in);
    chk(32'({flash_cs_n_out, user_io_release_out}), 32'h2, "status held");
    stat_hold <= 1'h0;
    wf(flash_cs_n_out, 1'h0, 50, "fetch start");
  endtask

  // Boundary-scan override and unknown strap code
  task automatic jt_run(input logic [3:0] c, input logic j, input int cnt);
    int n;
    logic [31:0] r;
    logic e;
    rst(c, j);
    fork
      por(n);
      apb(1'h1, ADDR_CTRL, 32'h3, r, e);
    join
    chk(32'(n > cnt && n <= cnt + 8), 32'h1, "por length");
    repeat (100) @(posedge ref_clk_in);
    apb(1'h0, ADDR_STATUS, 32'h0, r, e);
    chk(32'({r[5:0], flash_cs_n_out}), 32'({ST_HOLD, 1'h1}), "held");
    chk(32'({r[ST_COMPLETE_BIT:ST_JTAG_BIT], r[ST_SEL_LSB+3:ST_SEL_LSB]}), 32'({2'h1, j, c}), "strap");
  endtask

  // Register reset values, access kinds and an unmapped address
  task automatic reg_run();
    logic [31:0] r;
    logic e;
    rst(SEL_AS_STD_33, 1'h0);
    apb(1'h0, ADDR_CTRL, 32'h0, r, e);
    chk(r, 32'(CTRL_RESET), "ctrl reset");
    apb(1'h1, ADDR_CTRL, 32'h3, r, e);
    apb(1'h0, ADDR_CTRL, 32'h0, r, e);
    chk(r, 32'h3, "ctrl rw");
    apb(1'h1, ADDR_WORDS, 32'hFFFF, r, e);
    apb(1'h0, ADDR_WORDS, 32'h0, r, e);
    chk(r, 32'h0, "words ro");
    apb(1'h1, 12'hFFC, 32'h1, r, e);
    chk(32'(e), 32'h1, "unmapped err");
    apb(1'h0, 12'hFFC, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1, "unmapped read");
    // Clock enable low freezes the reset timer mid-window
    ce_in <= 1'h0;
    repeat (100) @(posedge ref_clk_in);
    chk(32'(status_line_oe_n_out), 32'h0, "frozen");
    ce_in <= 1'h1;
    wf(status_line_oe_n_out, 1'h1, 60, "por resume");
  endtask

  // Main sequence
  initial begin
    as_run(SEL_AS_FAST_33, 1'h1, 1'h1);
    as_run(SEL_AS_FAST_25, 1'h0, 1'h0);
    as_run(SEL_AS_STD_33, 1'h1, 1'h0);
    as_run(SEL_AS_STD_25, 1'h0, 1'h0);
    ctl_run();
    jt_run(SEL_AS_FAST_25, 1'h1, FC);
    jt_run(4'h0, 1'h0, SC);
    chk(32'(remote_update_active_out), 32'h0, "remote off");
    reg_run();
    wrap_up();
  end
endmodule
